// ==== pbmux_top.sv ====
// Purpose: Priority output mux for port B pins 4 to 7
// Assumes: Peripheral and latch inputs synchronous to core_clk
// Notes: Outputs are registered, one cycle behind the inputs
// Functional notes
// - With several peripherals enabled on a pin, the highest priority one drives it.
// - Pin levels always reach the input side, even while the pin is an output.
// - Overriding digital inputs take a place in the pin priority like outputs.
// - Order is pin4 first-I2C data; pin5 second-I2C data then serial data; pin6 clock; pin7 serial clock.
// - Serial data and clock join pins 5 and 7 only when the select registers route them there.
`include "pbmux_defines.svh"
module pbmux_top (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Port latches, tris high means input
  input wire logic [3:0] port_b_lat,
  input wire logic [3:0] port_b_tris,
  // Route selects from alt_pin_select_0 and alt_pin_select_1
  input wire logic sync_data_on_pin5,
  input wire logic sync_clk_on_pin7,
  // First I2C data
  input wire logic i2c1_data_en,
  input wire logic i2c1_data_out,
  input wire logic i2c1_data_oe,
  // Second I2C data
  input wire logic second_i2c_data_en,
  input wire logic second_i2c_data_out,
  input wire logic second_i2c_data_oe,
  // Receive or synchronous data, en also covers receive override
  input wire logic sync_serial_data_en,
  input wire logic sync_serial_data_out,
  input wire logic sync_serial_data_oe,
  // First I2C clock or SPI clock
  input wire logic i2c1_spi_clk_en,
  input wire logic i2c1_spi_clk_out,
  input wire logic i2c1_spi_clk_oe,
  // Transmit or synchronous clock
  input wire logic sync_serial_clock_en,
  input wire logic sync_serial_clock_out,
  input wire logic sync_serial_clock_oe,
  // Pads
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe,
  // Received pin levels for all input functions
  output logic [3:0] pin_level,
  // Current owner codes
  output pbmux_pkg::pbmux_owner_type owner_pin4,
  output pbmux_pkg::pbmux_owner_type owner_pin5,
  output pbmux_pkg::pbmux_owner_type owner_pin6,
  output pbmux_pkg::pbmux_owner_type owner_pin7
);
  // ==========================================================
  // State
  pbmux_pkg::pbmux_state_type st;
  pbmux_pkg::pbmux_state_type next_st;

  // Priority decode and drive selection per pin
  always_comb begin
    next_st = st;
    next_st.pin_in = pad_in;
    // Pin 4: first I2C data only
    if (i2c1_data_en) begin
      next_st.own4 = pbmux_pkg::own_i2c1_data;
    end else begin
      next_st.own4 = pbmux_pkg::own_latch;
    end
    // Pin 5: second I2C data beats routed serial data
    if (second_i2c_data_en) begin
      next_st.own5 = pbmux_pkg::own_i2c2_data;
    end else if (sync_serial_data_en && sync_data_on_pin5) begin
      next_st.own5 = pbmux_pkg::own_sync_data;
    end else begin
      next_st.own5 = pbmux_pkg::own_latch;
    end
    // Pin 6: shared I2C/SPI clock
    if (i2c1_spi_clk_en) begin
      next_st.own6 = pbmux_pkg::own_i2c1_spi_clk;
    end else begin
      next_st.own6 = pbmux_pkg::own_latch;
    end
    // Pin 7: routed serial clock
    if (sync_serial_clock_en && sync_clk_on_pin7) begin
      next_st.own7 = pbmux_pkg::own_sync_clk;
    end else begin
      next_st.own7 = pbmux_pkg::own_latch;
    end
    // Drive from the chosen owner; a receive override drives the pad from sync_serial_data_out and sync_serial_data_oe
    case (next_st.own4)
      pbmux_pkg::own_i2c1_data: begin
        next_st.pin_out[`PBMUX_PIN4] = i2c1_data_out;
        next_st.pin_oe[`PBMUX_PIN4] = i2c1_data_oe;
      end
      default: begin
        next_st.pin_out[`PBMUX_PIN4] = port_b_lat[`PBMUX_PIN4];
        next_st.pin_oe[`PBMUX_PIN4] = ~port_b_tris[`PBMUX_PIN4];
      end
    endcase
    case (next_st.own5)
      pbmux_pkg::own_i2c2_data: begin
        next_st.pin_out[`PBMUX_PIN5] = second_i2c_data_out;
        next_st.pin_oe[`PBMUX_PIN5] = second_i2c_data_oe;
      end
      pbmux_pkg::own_sync_data: begin
        next_st.pin_out[`PBMUX_PIN5] = sync_serial_data_out;
        next_st.pin_oe[`PBMUX_PIN5] = sync_serial_data_oe;
      end
      default: begin
        next_st.pin_out[`PBMUX_PIN5] = port_b_lat[`PBMUX_PIN5];
        next_st.pin_oe[`PBMUX_PIN5] = ~port_b_tris[`PBMUX_PIN5];
      end
    endcase
    case (next_st.own6)
      pbmux_pkg::own_i2c1_spi_clk: begin
        next_st.pin_out[`PBMUX_PIN6] = i2c1_spi_clk_out;
        next_st.pin_oe[`PBMUX_PIN6] = i2c1_spi_clk_oe;
      end
      default: begin
        next_st.pin_out[`PBMUX_PIN6] = port_b_lat[`PBMUX_PIN6];
        next_st.pin_oe[`PBMUX_PIN6] = ~port_b_tris[`PBMUX_PIN6];
      end
    endcase
    case (next_st.own7)
      pbmux_pkg::own_sync_clk: begin
        next_st.pin_out[`PBMUX_PIN7] = sync_serial_clock_out;
        next_st.pin_oe[`PBMUX_PIN7] = sync_serial_clock_oe;
      end
      default: begin
        next_st.pin_out[`PBMUX_PIN7] = port_b_lat[`PBMUX_PIN7];
        next_st.pin_oe[`PBMUX_PIN7] = ~port_b_tris[`PBMUX_PIN7];
      end
    endcase
  end

  // Register the state; reset leaves every pad released
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st.own4 <= pbmux_pkg::own_latch;
      st.own5 <= pbmux_pkg::own_latch;
      st.own6 <= pbmux_pkg::own_latch;
      st.own7 <= pbmux_pkg::own_latch;
      st.pin_out <= `PBMUX_RST_LAT;
      st.pin_oe <= `PBMUX_RST_OE;
      st.pin_in <= `PBMUX_RST_LEVEL;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign pad_out = st.pin_out;
  assign pad_oe = st.pin_oe;
  assign pin_level = st.pin_in;
  assign owner_pin4 = st.own4;
  assign owner_pin5 = st.own5;
  assign owner_pin6 = st.own6;
  assign owner_pin7 = st.own7;

  // ==========================================================
  // Assertions
  property p_pin5_priority;
    @(posedge core_clk) disable iff (srst)
      (clk_en && second_i2c_data_en) |=> (owner_pin5 == pbmux_pkg::own_i2c2_data);
  endproperty
  a_pin5_priority: assert property (p_pin5_priority) else $error("pin5 priority wrong");

  property p_level_follows;
    @(posedge core_clk) disable iff (srst)
      clk_en |=> (pin_level == $past(pad_in));
  endproperty
  a_level_follows: assert property (p_level_follows) else $error("pin level lost");

  property p_rx_override;
    @(posedge core_clk) disable iff (srst)
      (clk_en && !second_i2c_data_en && sync_serial_data_en && sync_data_on_pin5)
      |=> (owner_pin5 == pbmux_pkg::own_sync_data && pad_out[1] == $past(sync_serial_data_out));
  endproperty
  a_rx_override: assert property (p_rx_override) else $error("serial data not on pin5");

  property p_pin4_owner;
    @(posedge core_clk) disable iff (srst)
      (clk_en && i2c1_data_en) |=> (pad_oe[0] == $past(i2c1_data_oe));
  endproperty
  a_pin4_owner: assert property (p_pin4_owner) else $error("pin4 not from I2C");

  property p_pin6_owner;
    @(posedge core_clk) disable iff (srst)
      (clk_en && i2c1_spi_clk_en) |=> (pad_out[2] == $past(i2c1_spi_clk_out));
  endproperty
  a_pin6_owner: assert property (p_pin6_owner) else $error("pin6 not from clock");

  property p_route_gate;
    @(posedge core_clk) disable iff (srst)
      (clk_en && !sync_clk_on_pin7) |=> (owner_pin7 == pbmux_pkg::own_latch);
  endproperty
  a_route_gate: assert property (p_route_gate) else $error("unrouted clock on pin7");

  property p_latch_drive;
    @(posedge core_clk) disable iff (srst)
      (clk_en && !i2c1_spi_clk_en)
      |=> (pad_out[2] == $past(port_b_lat[2]) && pad_oe[2] == !$past(port_b_tris[2]));
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("pin6 latch drive wrong");

  property p_freeze;
    @(posedge core_clk) disable iff (srst)
      !clk_en |=> $stable(pad_out) && $stable(pad_oe);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  // Reset must release every pad whatever the peripherals still request
  property p_reset_release;
    @(posedge core_clk)
      srst |=> (pad_oe == `PBMUX_RST_OE && owner_pin5 == pbmux_pkg::own_latch);
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("pad driven after reset");

  // Main ownership cases worth seeing at least once
  c_pin5_i2c: cover property (@(posedge core_clk) owner_pin5 == pbmux_pkg::own_i2c2_data);
  c_pin5_rx: cover property (@(posedge core_clk) owner_pin5 == pbmux_pkg::own_sync_data);
  c_pin7_clk: cover property (@(posedge core_clk) owner_pin7 == pbmux_pkg::own_sync_clk);
  c_pin4_i2c: cover property (@(posedge core_clk) owner_pin4 == pbmux_pkg::own_i2c1_data);
endmodule // pbmux_top

// ==== pbmux_defines.svh ====
// Purpose: Constants for the port B upper pin output priority mux
// Assumes: Included by the mux package and design
// Notes: Pin indices are positions in the four-bit upper pin vectors
`ifndef PBMUX_DEFINES_SVH
`define PBMUX_DEFINES_SVH

// ==========================================================
// Pin positions within the upper pin vectors
`define PBMUX_PIN4 0
`define PBMUX_PIN5 1
`define PBMUX_PIN6 2
`define PBMUX_PIN7 3
`define PBMUX_NPINS 4

// ==========================================================
// Reset values: pads released, nothing seen on the level copy
`define PBMUX_RST_LAT 4'h0
`define PBMUX_RST_TRIS 4'hf
`define PBMUX_RST_OE 4'h0
`define PBMUX_RST_LEVEL 4'h0

`endif

// ==== pbmux_pkg.sv ====
// Purpose: Types for the port B upper pin output priority mux
// Assumes: Nothing beyond the defines header
// Notes: Owner names the source that drives one pin
`include "pbmux_defines.svh"
package pbmux_pkg;
  // ==========================================================
  // Which source owns a pin driver
  typedef enum logic [2:0] {
    own_latch,
    own_i2c1_data,
    own_i2c2_data,
    own_sync_data,
    own_i2c1_spi_clk,
    own_sync_clk
  } pbmux_owner_type;

  typedef struct packed {
    pbmux_owner_type own4;
    pbmux_owner_type own5;
    pbmux_owner_type own6;
    pbmux_owner_type own7;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pin_in;
  } pbmux_state_type;
endpackage

// ==== pbmux_partner.sv ====
// Purpose: Far side model: serial peripherals and the pad wire
// Assumes: Bench changes the peripheral vector at the falling edge
// Notes: A released pad shows the bench's external level, not the last driven one
module pbmux_partner (
  // Peripheral requests, en/out/oe per function
  input wire logic [14:0] req,
  output logic [14:0] periph,
  // Pad wire
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] ext_lvl,
  output logic [3:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Peripherals hold their request until the bench changes it
  assign periph = req;
  // Driven pads carry the driver, released pads the outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule // pbmux_partner

// ==== tb_port_b_output_priority_mux.sv ====
// Purpose: Self-checking bench for the pin 4 to 7 priority mux
// Assumes: Outputs one cycle behind inputs, clk_en high updates
// Notes: Levels are checked two edges after stimulus so pads settle
module tb_port_b_output_priority_mux;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] LA = pbmux_pkg::own_latch;
  localparam logic [2:0] D1 = pbmux_pkg::own_i2c1_data;
  localparam logic [2:0] D2 = pbmux_pkg::own_i2c2_data;
  localparam logic [2:0] SD = pbmux_pkg::own_sync_data;
  localparam logic [2:0] C1 = pbmux_pkg::own_i2c1_spi_clk;
  localparam logic [2:0] SC = pbmux_pkg::own_sync_clk;
  logic core_clk = 0, srst = 1, clk_en = 1;
  logic [3:0] lat = 0, tris = 4'hf, ext = 0, pad_in, pad_out, pad_oe, pin_level;
  logic [1:0] sel = 0;
  logic [14:0] req = 0, pv;
  pbmux_pkg::pbmux_owner_type o4, o5, o6, o7;
  int n_fail = 0, tests_run = 0, cycles = 0;
  // ==========================================================
  // Clock, hang guard
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 1000) begin
      n_fail++;
      wrap_up();
    end
  end
  pbmux_partner pbmux_partner_inst (.req(req), .periph(pv), .pad_out(pad_out),
    .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));
  pbmux_top pbmux_top_inst (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .port_b_lat(lat), .port_b_tris(tris), .sync_data_on_pin5(sel[0]),
    .sync_clk_on_pin7(sel[1]), .i2c1_data_en(pv[14]), .i2c1_data_out(pv[13]),
    .i2c1_data_oe(pv[12]), .second_i2c_data_en(pv[11]), .second_i2c_data_out(pv[10]),
    .second_i2c_data_oe(pv[9]), .sync_serial_data_en(pv[8]),
    .sync_serial_data_out(pv[7]), .sync_serial_data_oe(pv[6]), .i2c1_spi_clk_en(pv[5]),
    .i2c1_spi_clk_out(pv[4]), .i2c1_spi_clk_oe(pv[3]), .sync_serial_clock_en(pv[2]),
    .sync_serial_clock_out(pv[1]), .sync_serial_clock_oe(pv[0]), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pin_level(pin_level), .owner_pin4(o4),
    .owner_pin5(o5), .owner_pin6(o6), .owner_pin7(o7));
  // ==========================================================
  // Shared compare and stimulus step
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input logic [14:0] p, input logic [1:0] s, input logic [3:0] l,
    input logic [3:0] t, input logic [11:0] own, input logic [3:0] e_oe,
    input logic [3:0] e_out);
    req = p;
    sel = s;
    lat = l;
    tris = t;
    repeat (2) @(negedge core_clk);
    chk("owners", own, {o4, o5, o6, o7});
    chk("pad_oe", {8'h00, e_oe}, {8'h00, pad_oe});
    chk("pad_out", {8'h00, e_out & e_oe}, {8'h00, pad_out & pad_oe});
    chk("pin_level", {8'h00, (e_oe & e_out) | (~e_oe & ext)}, {8'h00, pin_level});
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset;
    chk("rst_owners", {LA, LA, LA, LA}, {o4, o5, o6, o7});
    chk("rst_oe", 12'h000, {8'h00, pad_oe});
    chk("rst_out", 12'h000, {8'h00, pad_out});
    chk("rst_level", 12'h000, {8'h00, pin_level});
  endtask
  task automatic s_latch;
    ext = 4'h5;
    step(15'h0000, 2'b11, 4'ha, 4'h3, {LA, LA, LA, LA}, 4'hc, 4'ha);
  endtask
  task automatic s_pin5;
    step(15'h0f40, 2'b01, 4'h0, 4'hf, {LA, D2, LA, LA}, 4'h2, 4'h2);
    step(15'h0140, 2'b01, 4'h0, 4'hf, {LA, SD, LA, LA}, 4'h2, 4'h0);
    step(15'h0140, 2'b00, 4'h0, 4'hf, {LA, LA, LA, LA}, 4'h0, 4'h0);
  endtask
  task automatic s_pins467;
    step(15'h702f, 2'b10, 4'h0, 4'hf, {D1, LA, C1, SC}, 4'hd, 4'h9);
    step(15'h702f, 2'b00, 4'h0, 4'hf, {D1, LA, C1, LA}, 4'h5, 4'h1);
  endtask
  task automatic s_override;
    ext = 4'h0;
    step(15'h0100, 2'b01, 4'hf, 4'h0, {LA, SD, LA, LA}, 4'hd, 4'hf);
  endtask
  task automatic s_freeze;
    clk_en = 0;
    req = 15'h7000;
    repeat (2) @(negedge core_clk);
    chk("frozen", {LA, SD, LA, LA}, {o4, o5, o6, o7});
    chk("frozen_oe", 12'h00d, {8'h00, pad_oe});
    clk_en = 1;
  endtask
  // Reset in mid-run with a peripheral still claiming pin 4
  task automatic s_midreset;
    srst = 1;
    repeat (2) @(negedge core_clk);
    chk("mid_owners", {LA, LA, LA, LA}, {o4, o5, o6, o7});
    chk("mid_oe", 12'h000, {8'h00, pad_oe});
    srst = 0;
    repeat (2) @(negedge core_clk);
    chk("resume", {D1, LA, LA, LA}, {o4, o5, o6, o7});
  endtask
  // ==========================================================
  // Verdict and end of run
  task automatic wrap_up;
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    srst = 0;
    s_reset();
    s_latch();
    s_pin5();
    s_pins467();
    s_override();
    s_freeze();
    s_midreset();
    wrap_up();
  end
endmodule // tb_port_b_output_priority_mux
